//--- hdl/acrx_pkg.sv
// Shared constants and types for the ATM cell receive port
`default_nettype none
package acrx_pkg;
    // Link widths
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned ADDR_W = 5;
    // Octets in one cell
    localparam int unsigned CELL_BYTES = 53;
    localparam logic [5:0] CELL_LAST = 6'h34;
    // Byte count at which enable rises, one before the last
    localparam logic [5:0] CELL_STOP = 6'h33;
    // Highest PHY address that is polled
    localparam logic [4:0] ADDR_MAX = 5'h1f;
    // Reset values of the driven pins
    localparam logic [4:0] ADDR_RST = 5'h00;
    localparam logic ENB_RST = 1'b1;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // Receive pins idle high through their pull-ups
    localparam logic PIN_IDLE = 1'b1;
    // Port state machine
    typedef enum logic [2:0] {
        S_POLL, S_CLAV, S_SEL, S_CELL, S_SINGLE_PHY_MODE
    } acrx_state_type;
endpackage
`default_nettype wire

//--- hdl/acrx_sync.sv
// Two-flop synchroniser for one input bit
`default_nettype none
module acrx_sync (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_d,
    output logic o_q
);
    logic meta_reg;
    // First flop is read only by the second
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            // Pull-up level, so an idle pin shows no edge after reset
            meta_reg <= acrx_pkg::PIN_IDLE;
            o_q <= acrx_pkg::PIN_IDLE;
        end else if (i_ce) begin
            meta_reg <= i_d;
            o_q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

//--- hdl/acrx_port.sv
// ATM cell receive port: polls PHYs, selects one, captures cells
// Notes on behaviour
// - Sample receive inputs on link clock rising edge
// - Cell data travels over eight-bit bus
// - Drive five-bit address to poll, select
// - Single-PHY: enable low means ready
// - Enable decides which PHY drives data
// - Address with enable high, then low
`default_nettype none
module acrx_port (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_multi_phy_mode,
    input wire logic i_rx_cell_clock,
    input wire logic i_rx_cell_available_in,
    input wire logic i_rx_start_of_cell,
    input wire logic [7:0] i_rx_cell_byte,
    input wire logic i_sink_ready,
    output logic [4:0] o_rx_phy_select_address,
    output logic o_rx_enable_out_n,
    output logic [7:0] o_byte,
    output logic o_byte_valid,
    output logic o_byte_first,
    output logic [4:0] o_byte_phy
);
    ////////////////////////////////////////////////////////////////
    // Synchronisers for every pin input
    logic [10:0] pin_raw;
    logic [10:0] pin_sync;
    assign pin_raw = {i_rx_cell_clock, i_rx_cell_available_in,
                      i_rx_start_of_cell, i_rx_cell_byte};
    genvar gi;
    generate
        for (gi = 0; gi < 11; gi++) begin : g_sync
            acrx_sync u_sync (
                .i_clk(i_clk),
                .i_reset(i_reset),
                .i_ce(i_ce),
                .i_d(pin_raw[gi]),
                .o_q(pin_sync[gi])
            );
        end
    endgenerate
    logic lclk_s;
    logic clav_s;
    logic soc_s;
    logic [7:0] data_s;
    assign lclk_s = pin_sync[10];
    assign clav_s = pin_sync[9];
    assign soc_s = pin_sync[8];
    assign data_s = pin_sync[7:0];

    ////////////////////////////////////////////////////////////////
    // Link clock edge finder; delayed copy of data kept aligned
    logic lclk_d_reg;
    logic clav_d_reg; // Pins as they stood just before the edge
    logic soc_d_reg;
    logic [7:0] data_d_reg;
    logic rise;
    // Copies are one cycle old: taken while the clock was still low,
    // so a PHY output moving just after the edge is never half caught
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            lclk_d_reg <= acrx_pkg::PIN_IDLE;
            clav_d_reg <= acrx_pkg::PIN_IDLE;
            soc_d_reg <= acrx_pkg::PIN_IDLE;
            data_d_reg <= acrx_pkg::BYTE_RST;
        end else if (i_ce) begin
            lclk_d_reg <= lclk_s;
            clav_d_reg <= clav_s;
            soc_d_reg <= soc_s;
            data_d_reg <= data_s;
        end
    end
    // Every receive input is taken only at a link rising edge
    assign rise = lclk_s & ~lclk_d_reg;

    ////////////////////////////////////////////////////////////////
    // Port sequencer
    acrx_pkg::acrx_state_type state_reg;
    logic [4:0] addr_reg;
    logic enb_n_reg;
    logic [5:0] cnt_reg;
    logic [4:0] sel_reg;
    logic enb_seen_n_reg; // Enable as the PHY sampled it last edge
    logic cell_byte; // A cell byte stands at this edge
    // A PHY answers the enable it saw one link edge back, so bytes are
    // judged against that copy rather than the live pin
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            enb_seen_n_reg <= acrx_pkg::ENB_RST;
        end else if (i_ce && rise) begin
            enb_seen_n_reg <= enb_n_reg;
        end
    end
    // Bytes counted from start of cell while selected
    assign cell_byte = state_reg == acrx_pkg::S_CELL && !enb_seen_n_reg &&
        (soc_d_reg || cnt_reg != 6'h00);
    // Drives change on rising edges only, so the PHY sees them stable
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= acrx_pkg::S_POLL;
            addr_reg <= acrx_pkg::ADDR_RST;
            enb_n_reg <= acrx_pkg::ENB_RST;
            cnt_reg <= 6'h00;
            sel_reg <= acrx_pkg::ADDR_RST;
        end else if (i_ce && rise) begin
            case (state_reg)
                acrx_pkg::S_POLL: begin
                    // Put address out, enable high
                    enb_n_reg <= 1'b1;
                    if (!i_multi_phy_mode) begin
                        state_reg <= acrx_pkg::S_SINGLE_PHY_MODE;
                    end else begin
                        state_reg <= acrx_pkg::S_CLAV;
                    end
                end
                acrx_pkg::S_CLAV: begin
                    // Answer to the address driven one clock earlier
                    if (clav_d_reg && i_sink_ready) begin
                        sel_reg <= addr_reg;
                        enb_n_reg <= 1'b0;
                        cnt_reg <= 6'h00;
                        state_reg <= acrx_pkg::S_CELL;
                    end else begin
                        // Unavailable or sink not ready: move to next PHY
                        addr_reg <= (addr_reg == acrx_pkg::ADDR_MAX) ?
                            5'h00 : addr_reg + 5'h01;
                        state_reg <= acrx_pkg::S_POLL;
                    end
                end
                acrx_pkg::S_CELL: begin
                    // Only the selected PHY drives data now
                    if (cell_byte) begin
                        cnt_reg <= cnt_reg + 6'h01;
                        // Enable rises one byte early: the PHY still
                        // owes the byte it launched on that edge
                        if (cnt_reg == acrx_pkg::CELL_STOP) begin
                            enb_n_reg <= 1'b1;
                        end
                        if (cnt_reg == acrx_pkg::CELL_LAST) begin
                            cnt_reg <= 6'h00;
                            addr_reg <= (addr_reg == acrx_pkg::ADDR_MAX) ?
                                5'h00 : addr_reg + 5'h01;
                            state_reg <= acrx_pkg::S_POLL;
                        end
                    end
                end
                acrx_pkg::S_SINGLE_PHY_MODE: begin
                    // Single PHY: enable low while the sink can accept
                    enb_n_reg <= ~i_sink_ready;
                    if (i_multi_phy_mode) begin
                        enb_n_reg <= 1'b1;
                        state_reg <= acrx_pkg::S_POLL;
                    end
                end
                default: begin
                    state_reg <= acrx_pkg::S_POLL;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Byte capture; enable low in the prior cycle means a transfer
    // Limitation: sink must accept any byte while enable is low
    logic take;
    assign take = rise && (cell_byte || (state_reg == acrx_pkg::S_SINGLE_PHY_MODE &&
        !enb_seen_n_reg && clav_d_reg));
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_byte <= acrx_pkg::BYTE_RST;
            o_byte_valid <= 1'b0;
            o_byte_first <= 1'b0;
            o_byte_phy <= acrx_pkg::ADDR_RST;
        end else if (i_ce) begin
            o_byte_valid <= take;
            if (take) begin
                o_byte <= data_d_reg;
                o_byte_first <= soc_d_reg;
                o_byte_phy <= sel_reg;
            end
        end
    end

    // Pins straight from flops
    assign o_rx_phy_select_address = addr_reg;
    assign o_rx_enable_out_n = enb_n_reg;

    ////////////////////////////////////////////////////////////////
    // Checks
    property p_edge_only;
        @(posedge i_clk) disable iff (i_reset)
        $changed(enb_n_reg) |-> $past(rise);
    endproperty
    a_edge_only: assert property (p_edge_only)
        else $error("Enable moved without link edge");
    property p_sel_seq;
        @(posedge i_clk) disable iff (i_reset)
        $fell(enb_n_reg) && i_multi_phy_mode |->
            $past(state_reg) == acrx_pkg::S_CLAV;
    endproperty
    a_sel_seq: assert property (p_sel_seq)
        else $error("Select without prior high enable");
    property p_addr_hold;
        @(posedge i_clk) disable iff (i_reset)
        state_reg == acrx_pkg::S_CELL |-> $stable(addr_reg);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("Address moved during cell");
    property p_valid_cause;
        @(posedge i_clk) disable iff (i_reset)
        o_byte_valid |-> $past(rise) && !$past(enb_seen_n_reg);
    endproperty
    a_valid_cause: assert property (p_valid_cause)
        else $error("Byte without enable");
    property p_first;
        @(posedge i_clk) disable iff (i_reset)
        o_byte_valid && o_byte_first |-> $past(soc_d_reg);
    endproperty
    a_first: assert property (p_first)
        else $error("First flag without start of cell");
    property p_single_phy_mode_enb;
        @(posedge i_clk) disable iff (i_reset)
        rise && state_reg == acrx_pkg::S_SINGLE_PHY_MODE && i_sink_ready &&
            !i_multi_phy_mode |=> !enb_n_reg;
    endproperty
    a_single_phy_mode_enb: assert property (p_single_phy_mode_enb)
        else $error("Single PHY enable not asserted");
    property p_step;
        @(posedge i_clk) disable iff (i_reset)
        rise && state_reg == acrx_pkg::S_CLAV && !clav_d_reg |=>
            addr_reg == $past(addr_reg) + 5'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("Poll address did not advance");
    property p_cell_len;
        @(posedge i_clk) disable iff (i_reset)
        $rose(enb_n_reg) && $past(state_reg) == acrx_pkg::S_CELL |->
            $past(cnt_reg) == acrx_pkg::CELL_STOP;
    endproperty
    a_cell_len: assert property (p_cell_len)
        else $error("Cell length wrong");
    // Cell closes only after its last byte, with enable already high
    property p_cell_end;
        @(posedge i_clk) disable iff (i_reset)
        $past(state_reg) == acrx_pkg::S_CELL &&
            state_reg == acrx_pkg::S_POLL |->
            $past(cnt_reg) == acrx_pkg::CELL_LAST && enb_n_reg;
    endproperty
    a_cell_end: assert property (p_cell_end)
        else $error("Cell closed at wrong byte");
    c_single: cover property (@(posedge i_clk)
        take && state_reg == acrx_pkg::S_SINGLE_PHY_MODE);
    c_select: cover property (@(posedge i_clk) $fell(enb_n_reg));
    c_first: cover property (@(posedge i_clk) o_byte_first);
    c_wrap: cover property (@(posedge i_clk)
        addr_reg == acrx_pkg::ADDR_MAX);
endmodule
`default_nettype wire

//--- sim/acrx_phy_model.sv
// Behavioural PHY side: answers polls and sends cells
`default_nettype none
module acrx_phy_model #(
    parameter logic [4:0] CELL_ADDR = 5'h05
) (
    input wire logic i_link_clk,
    input wire logic i_multi,
    input wire logic i_offer,
    input wire logic [4:0] i_addr,
    input wire logic i_enb_n,
    output logic o_clav,
    output logic o_soc,
    output logic [7:0] o_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sel_reg = 1'b0; // Chosen by the address before enable fell
    logic [5:0] cnt_reg = 6'h00; // Bytes sent of this cell
    initial begin
        o_clav = 1'b0;
        o_soc = 1'b0;
        o_byte = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////
    // All pins change just after the link clock rises
    always @(posedge i_link_clk) begin
        if (!i_offer) cnt_reg <= 6'h00;
        // Stands for every address: low unless ours with a full cell
        o_clav <= i_offer && cnt_reg != 6'h35 &&
            (!i_multi || i_addr == CELL_ADDR);
        if (i_enb_n && i_multi) sel_reg <= (i_addr == CELL_ADDR);
        if (!i_enb_n && i_offer && (sel_reg || !i_multi) &&
            cnt_reg != 6'h35) begin
            o_soc <= (cnt_reg == 6'h00);
            o_byte <= 8'ha0 + {2'b00, cnt_reg};
            cnt_reg <= (!i_multi && cnt_reg == 6'h34) ? 6'h00 :
                cnt_reg + 6'h01;
        end else begin
            // Released lines float: never show a stale value
            o_soc <= ~o_soc;
            o_byte <= ~o_byte;
        end
    end
endmodule
`default_nettype wire

//--- sim/acrx_port_tb_top.sv
// Testbench for the ATM cell receive port
`default_nettype none
module acrx_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] PHY = 5'h05;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic link = 1'b0;
    logic multi = 1'b1;
    logic ready = 1'b0;
    logic offer = 1'b0;
    logic ce = 1'b1;
    logic clav, soc, enb_n, o_byte_valid, o_byte_first;
    logic [7:0] pin_byte, o_byte;
    logic [4:0] addr, o_byte_phy;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    always #10 i_clk = ~i_clk;
    // Link clock runs free at eight i_clk periods, each rise 3 ns before an i_clk rise
    initial begin
        #7;
        forever #80 link = ~link;
    end
    acrx_port acrx_port_i (.i_clk(i_clk), .i_reset(i_reset),
        .i_ce(ce), .i_multi_phy_mode(multi), .i_rx_cell_clock(link),
        .i_rx_cell_available_in(clav), .i_rx_start_of_cell(soc),
        .i_rx_cell_byte(pin_byte), .i_sink_ready(ready),
        .o_rx_phy_select_address(addr), .o_rx_enable_out_n(enb_n),
        .o_byte(o_byte), .o_byte_valid(o_byte_valid),
        .o_byte_first(o_byte_first), .o_byte_phy(o_byte_phy));
    acrx_phy_model #(.CELL_ADDR(PHY)) acrx_phy_model_i (
        .i_link_clk(link), .i_multi(multi), .i_offer(offer),
        .i_addr(addr), .i_enb_n(enb_n), .o_clav(clav), .o_soc(soc),
        .o_byte(pin_byte));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bounded wait for the next captured byte
    task automatic wait_valid();
        int n;
        n = 0;
        @(negedge i_clk);
        while (o_byte_valid !== 1'b1 && n < 3000) begin
            @(negedge i_clk);
            n++;
        end
        if (n == 3000) chk(8'h00, 8'h01);
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Sink not ready: polling walks all addresses, nobody selected
    task automatic test_refused();
        logic [4:0] last;
        int moves;
        ready = 1'b0;
        offer = 1'b1;
        last = addr;
        moves = 0;
        repeat (640) begin
            @(negedge i_clk);
            chk({7'h00, enb_n}, 8'h01);
            chk({7'h00, o_byte_valid}, 8'h00);
            if (addr !== last) begin
                chk({3'h0, addr}, {3'h0, last + 5'h01});
                moves++;
                last = addr;
            end
        end
        chk({7'h00, moves > 32}, 8'h01);
    endtask
    // Clock enable low: address and enable hold, then polling resumes
    task automatic test_freeze();
        logic [4:0] held;
        held = addr;
        ce = 1'b0;
        repeat (400) begin
            @(negedge i_clk);
            chk({3'h0, addr}, {3'h0, held});
            chk({7'h00, enb_n}, 8'h01);
        end
        ce = 1'b1;
        repeat (64) @(negedge i_clk);
        chk({7'h00, addr != held}, 8'h01);
    endtask
    // Ready sink: the offering PHY is selected and one cell arrives
    task automatic test_cell();
        ready = 1'b1;
        for (int k = 0; k < 53; k++) begin
            wait_valid();
            chk(o_byte, 8'ha0 + k[7:0]);
            chk({7'h00, o_byte_first}, {7'h00, k == 0});
            chk({3'h0, o_byte_phy}, {3'h0, PHY});
        end
        repeat (40) @(negedge i_clk);
        chk({7'h00, enb_n}, 8'h01);
        offer = 1'b0;
    endtask
    // Single PHY: enable follows readiness, octets flow
    task automatic test_single();
        multi = 1'b0;
        ready = 1'b0;
        repeat (40) @(negedge i_clk);
        offer = 1'b1;
        repeat (80) @(negedge i_clk);
        chk({7'h00, enb_n}, 8'h01);
        ready = 1'b1;
        for (int k = 0; k < 4; k++) begin
            wait_valid();
            chk(o_byte, 8'ha0 + k[7:0]);
            chk({7'h00, o_byte_first}, {7'h00, k == 0});
        end
        ready = 1'b0;
        repeat (40) @(negedge i_clk);
        chk({7'h00, enb_n}, 8'h01);
    endtask
    // Hang guard, well above the few thousand cycles needed
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (10) @(negedge i_clk);
        i_reset = 1'b0;
        test_refused();
        test_freeze();
        test_cell();
        test_single();
        print_verdict();
    end
endmodule
`default_nettype wire
